// *** rtl/tcc_pkg.sv ***
// Constants, register map and field layout of the timer channel capture core.
// Assumes a 200 MHz pclk and a 32-bit APB register port with 8-bit addresses.
package tcc_pkg;

  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned SLOW_HZ     = 32_768;
  localparam int unsigned SLOW_DIV    = CLK_HZ / SLOW_HZ;
  localparam int unsigned TICK_DIV_W  = 7;

  // Register byte offsets.
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_SETUP    = 8'h04;
  localparam logic [7:0] OFS_COUNT    = 8'h08;
  localparam logic [7:0] OFS_CAP_A    = 8'h0c;
  localparam logic [7:0] OFS_CAP_B    = 8'h10;
  localparam logic [7:0] OFS_CMP_C    = 8'h14;
  localparam logic [7:0] OFS_NEXT     = 8'h18;
  localparam logic [7:0] OFS_FLAGS    = 8'h1c;
  localparam logic [7:0] OFS_BLK_CMD  = 8'h20;
  localparam logic [7:0] OFS_ROUTING  = 8'h24;

  // channel_command bits.
  localparam int unsigned CMD_CLK_EN  = 0;
  localparam int unsigned CMD_CLK_DIS = 1;
  localparam int unsigned CMD_KICK    = 2;
  // block_command bits.
  localparam int unsigned BLK_SYNC    = 0;

  // channel_setup fields.
  localparam int unsigned SET_SRC     = 0;   // 3 bits
  localparam int unsigned SET_INV     = 3;
  localparam int unsigned SET_BURST   = 4;   // 2 bits
  localparam int unsigned SET_STOP_B  = 6;
  localparam int unsigned SET_DIS_B   = 7;
  localparam int unsigned SET_TRG_EDG = 8;   // 2 bits
  localparam int unsigned SET_TRG_B   = 10;
  localparam int unsigned SET_EVT_SRC = 11;  // 2 bits
  localparam int unsigned SET_EVT_EN  = 13;
  localparam int unsigned SET_C_RST   = 14;
  localparam int unsigned SET_MODE    = 15;
  localparam int unsigned SET_LD_A    = 16;  // 2 bits
  localparam int unsigned SET_LD_B    = 18;  // 2 bits
  localparam int unsigned SET_DECIM   = 20;  // 3 bits
  localparam int unsigned SET_STOP_C  = 24;
  localparam int unsigned SET_DIS_C   = 25;
  localparam logic [31:0] SET_MASK    = 32'h037fffff;

  // channel_flags bits.
  localparam int unsigned FLG_OVF     = 0;
  localparam int unsigned FLG_OVR     = 1;
  localparam int unsigned FLG_CLK_EN  = 16;

  localparam logic [31:0] RST_WORD    = 32'h00000000;
  localparam logic [5:0]  RST_ROUTING = 6'h00;
  localparam logic [15:0] WRAP_LOW    = 16'hffff;
  localparam logic [2:0]  SRC_EXT0    = 3'h5;

  typedef enum logic [1:0] {
    TCC_EDGE_NONE = 2'b00,
    TCC_EDGE_RISE = 2'b01,
    TCC_EDGE_FALL = 2'b10,
    TCC_EDGE_BOTH = 2'b11
  } tcc_edge_e;

endpackage : tcc_pkg

// *** rtl/tcc_pins_if.sv ***
// Carrier for synchronised pin levels and their one-cycle edge pulses.
// Assumes one pclk domain on both sides.
`timescale 1ns/10ps
`default_nettype none
interface tcc_pins_if #(parameter int unsigned W = 7);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, rise, fall);
  modport dst (input lvl, rise, fall);
endinterface : tcc_pins_if
`default_nettype wire

// *** rtl/tcc_sync.sv ***
// Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes each pin level is held longer than one pclk period.
`timescale 1ns/10ps
`default_nettype none
module tcc_sync #(
  parameter int unsigned W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  tcc_pins_if.src           pins
);
  logic [W-1:0] meta_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] old_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      lvl_q  <= '0;
      old_q  <= '0;
    end else begin
      meta_q <= raw;
      lvl_q  <= meta_q;
      old_q  <= lvl_q;
    end
  end

  assign pins.lvl  = lvl_q;
  assign pins.rise = lvl_q & ~old_q;
  assign pins.fall = ~lvl_q & old_q;
endmodule : tcc_sync
`default_nettype wire

// *** rtl/tcc_ticks.sv ***
// Internal tick sources: one-cycle pulses at pclk/2, /8, /32, /128 and a slow rate.
// Assumes a free-running pclk; the slow divider is shortened in simulation.
`timescale 1ns/10ps
`default_nettype none
module tcc_ticks
  import tcc_pkg::*;
#(
  parameter int unsigned SLOW_CYC = SLOW_DIV
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic      [4:0] tick
);
  localparam int unsigned SW = $clog2(SLOW_CYC + 1);
  localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_CYC - 1);

  logic [TICK_DIV_W-1:0] div_q;
  logic [SW-1:0]         slow_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      slow_q <= '0;
      tick   <= '0;
    end else begin
      div_q    <= div_q + 1'b1;
      slow_q   <= (slow_q == SLOW_LAST) ? '0 : slow_q + 1'b1;
      tick[0]  <= &div_q[0:0];
      tick[1]  <= &div_q[2:0];
      tick[2]  <= &div_q[4:0];
      tick[3]  <= &div_q[6:0];
      tick[4]  <= (slow_q == SLOW_LAST);
    end
  end
endmodule : tcc_ticks
`default_nettype wire

// *** rtl/tcc_top.sv ***
// One timer channel core: counter, clock selection and control, triggers and capture A/B.
// Assumes an APB master on pclk and asynchronous clock and line pins from outside.
//
// How it works
// - a 32-bit counter adds one on each selected clock edge.
// - the low 16 bits passing 0xFFFF to 0x0000 set the count overflow flag.
// - a trigger zeroes the counter at the next valid selected clock edge.
// - each external clock input routes from its outside pin or a peer line A.
// - clock source picks one of five internal ticks or three external clocks.
// - clock invert counts on the falling edges of the selected external clock.
// - burst gating passes clock edges only while a chosen external clock is high.
// - enable and disable commands, B-load or C-match disable; disabled ignores start/stop.
// - the flags register shows whether the counter clock is enabled.
// - any trigger starts the clock; B-load or C-match may stop it when enabled.
// - mode bit picks capture or generator; generator drives line A, maybe line B.
// - the soft kick command bit triggers the channel.
// - the block sync command triggers the channel like a soft kick.
// - with C-match restart set, counter equal to compare C triggers.
// - external trigger from line A/B in capture, or gated event in generator.
// - capture A and B load on line A edges, decimated by 1 to 16.
// - A loads only if unloaded since trigger or B loaded after it.
// - B loads only if A loaded since trigger or B's last load.
// - reloading an unread capture overwrites it and sets the overrun flag.
// - next-unread register returns A/B in load order; each load requests DMA.
`timescale 1ns/10ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
#(
  parameter int unsigned SLOW_CYC = tcc_pkg::SLOW_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  outside_clock_pin,
  input  wire logic [1:0]  peer_line_a,
  input  wire logic        line_a_pin_i,
  output logic             line_a_pin_o,
  output logic             line_a_pin_oe_n,
  input  wire logic        line_b_pin_i,
  output logic             line_b_pin_o,
  output logic             line_b_pin_oe_n,
  output logic             dma_req
);
  import tcc_pkg::*;

  function automatic logic edge_hit(input logic [1:0] kind, input logic r, input logic f);
    edge_hit = (kind[0] & r) | (kind[1] & f);
  endfunction : edge_hit

  // Sync vector: [2:0] outside clocks, [4:3] peer line A, [5] line A, [6] line B.
  tcc_pins_if #(.W(7)) pins ();
  tcc_sync #(.W(7)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({line_b_pin_i, line_a_pin_i, peer_line_a, outside_clock_pin}),
    .pins    (pins)
  );

  logic [4:0] tick;
  tcc_ticks #(.SLOW_CYC(SLOW_CYC)) u_ticks (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  logic [31:0] setup_q;
  logic [31:0] cmp_c_q;
  logic [5:0]  routing_q;
  logic [31:0] count_q;
  logic [31:0] cap_a_q;
  logic [31:0] cap_b_q;
  logic        en_q;
  logic        run_q;
  logic        trig_pend_q;
  logic        ovf_q;
  logic        ovr_q;
  logic        a_armed_q;
  logic        a_unread_q;
  logic        b_unread_q;
  logic        a_newer_q;
  logic        c_eq_q;
  logic [3:0]  decim_q;
  logic        drive_q;

  // APB: one wait state. Writes land at the pready edge, but clear-on-read effects happen
  // at the edge that registers prdata, so an event between snapshot and clear is not lost.
  logic acc;
  logic wr;
  logic rd;
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = psel & penable & ~pready & ~pwrite;

  logic gen_mode;
  logic [2:0] src;
  logic [1:0] burst;
  assign gen_mode = setup_q[SET_MODE];
  assign src      = setup_q[SET_SRC +: 3];
  assign burst    = setup_q[SET_BURST +: 2];

  // Routing of the three external clock inputs.
  logic [2:0] xc_lvl;
  logic [2:0] xc_rise;
  logic [2:0] xc_fall;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      unique case (routing_q[2*i +: 2])
        2'b00: begin
          xc_lvl[i]  = pins.lvl[i];
          xc_rise[i] = pins.rise[i];
          xc_fall[i] = pins.fall[i];
        end
        2'b01: begin
          xc_lvl[i]  = 1'b0;
          xc_rise[i] = 1'b0;
          xc_fall[i] = 1'b0;
        end
        2'b10: begin
          xc_lvl[i]  = pins.lvl[3];
          xc_rise[i] = pins.rise[3];
          xc_fall[i] = pins.fall[3];
        end
        2'b11: begin
          xc_lvl[i]  = pins.lvl[4];
          xc_rise[i] = pins.rise[4];
          xc_fall[i] = pins.fall[4];
        end
      endcase
    end
  end

  // Counter clock edge: selection, inversion and burst gating.
  logic sel_edge;
  logic gate;
  logic cnt_edge;
  logic [1:0] xsel;
  assign xsel = 2'(src - SRC_EXT0);
  always_comb begin
    if (src < SRC_EXT0) begin
      sel_edge = tick[src];
    end else if (xsel > 2'd2) begin
      sel_edge = 1'b0;
    end else if (setup_q[SET_INV]) begin
      sel_edge = xc_fall[xsel];
    end else begin
      sel_edge = xc_rise[xsel];
    end
  end
  assign gate     = (burst == 2'b00) ? 1'b1 : xc_lvl[burst - 2'd1];
  assign cnt_edge = sel_edge & gate;

  // Compare C event on the cycle the counter first equals compare C.
  logic c_hit;
  assign c_hit = (count_q == cmp_c_q) & ~c_eq_q;

  // Trigger sources.
  logic kick;
  logic sync;
  logic ext_trg;
  logic c_trg;
  logic trig;
  logic [1:0] trg_edg;
  logic [1:0] evt_src;
  logic evt_r;
  logic evt_f;
  assign kick    = wr & (paddr == OFS_CMD) & pwdata[CMD_KICK];
  assign sync    = wr & (paddr == OFS_BLK_CMD) & pwdata[BLK_SYNC];
  assign c_trg   = c_hit & setup_q[SET_C_RST];
  assign trg_edg = setup_q[SET_TRG_EDG +: 2];
  assign evt_src = setup_q[SET_EVT_SRC +: 2];
  always_comb begin
    if (!gen_mode) begin
      evt_r = setup_q[SET_TRG_B] ? pins.rise[6] : pins.rise[5];
      evt_f = setup_q[SET_TRG_B] ? pins.fall[6] : pins.fall[5];
    end else if (evt_src == 2'b00) begin
      evt_r = pins.rise[6];
      evt_f = pins.fall[6];
    end else begin
      evt_r = xc_rise[evt_src - 2'd1];
      evt_f = xc_fall[evt_src - 2'd1];
    end
  end
  assign ext_trg = edge_hit(trg_edg, evt_r, evt_f) & (~gen_mode | setup_q[SET_EVT_EN]);
  assign trig    = kick | sync | c_trg | ext_trg;

  // Capture selection on line A with decimation.
  logic ld_a_sel;
  logic ld_b_sel;
  logic cap_evt;
  logic dec_fire;
  logic [3:0] dec_last;
  logic load_a;
  logic load_b;
  assign ld_a_sel = edge_hit(setup_q[SET_LD_A +: 2], pins.rise[5], pins.fall[5]);
  assign ld_b_sel = edge_hit(setup_q[SET_LD_B +: 2], pins.rise[5], pins.fall[5]);
  assign cap_evt  = ~gen_mode & (ld_a_sel | ld_b_sel);
  assign dec_last = 4'((5'd1 << setup_q[SET_DECIM +: 3]) - 5'd1);
  assign dec_fire = cap_evt & (decim_q >= dec_last);
  assign load_a   = dec_fire & ld_a_sel & ~a_armed_q;
  assign load_b   = dec_fire & ld_b_sel & a_armed_q & ~load_a;

  // Stop and disable events.
  logic stop_evt;
  logic dis_evt;
  assign stop_evt = (load_b & setup_q[SET_STOP_B]) | (gen_mode & c_hit & setup_q[SET_STOP_C]);
  assign dis_evt  = (wr & (paddr == OFS_CMD) & pwdata[CMD_CLK_DIS])
                  | (load_b & setup_q[SET_DIS_B])
                  | (gen_mode & c_hit & setup_q[SET_DIS_C]);

  // Next unread capture: the older of the unread values.
  logic next_is_a;
  assign next_is_a = a_unread_q & ~(b_unread_q & a_newer_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q   <= RST_WORD;
      cmp_c_q   <= RST_WORD;
      routing_q <= RST_ROUTING;
    end else if (wr) begin
      if (paddr == OFS_SETUP) setup_q <= pwdata & SET_MASK;
      if (paddr == OFS_CMP_C) cmp_c_q <= pwdata;
      if (paddr == OFS_ROUTING) routing_q <= pwdata[5:0];
    end
  end

  // Clock enable and start/stop; disable wins over a simultaneous enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= 1'b0;
      run_q <= 1'b0;
    end else if (dis_evt) begin
      en_q  <= 1'b0;
      run_q <= 1'b0;
    end else begin
      if (wr && paddr == OFS_CMD && pwdata[CMD_CLK_EN]) en_q <= 1'b1;
      if (en_q && trig) run_q <= 1'b1;
      else if (en_q && stop_evt) run_q <= 1'b0;
    end
  end

  // Counter; a pending trigger zeroes it at the next gated clock edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q     <= RST_WORD;
      trig_pend_q <= 1'b0;
      c_eq_q      <= 1'b0;
    end else begin
      c_eq_q <= (count_q == cmp_c_q);
      if (cnt_edge && trig_pend_q) begin
        count_q     <= RST_WORD;
        trig_pend_q <= trig;
      end else begin
        if (trig) trig_pend_q <= 1'b1;
        if (cnt_edge && en_q && run_q) count_q <= count_q + 32'h00000001;
      end
    end
  end

  // Sticky flags: an event in the clearing read's cycle stays set.
  logic flags_rd;
  logic wrap;
  assign flags_rd = rd & (paddr == OFS_FLAGS);
  assign wrap     = cnt_edge & en_q & run_q & ~trig_pend_q & (count_q[15:0] == WRAP_LOW);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      ovf_q <= wrap | (ovf_q & ~flags_rd);
      ovr_q <= (load_a & a_unread_q) | (load_b & b_unread_q) | (ovr_q & ~flags_rd);
    end
  end

  // Capture loads, order tracking and unread state.
  logic rd_a;
  logic rd_b;
  assign rd_a = rd & ((paddr == OFS_CAP_A) | ((paddr == OFS_NEXT) & next_is_a));
  assign rd_b = rd & ((paddr == OFS_CAP_B) | ((paddr == OFS_NEXT) & ~next_is_a));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_a_q    <= RST_WORD;
      cap_b_q    <= RST_WORD;
      a_armed_q  <= 1'b0;
      a_unread_q <= 1'b0;
      b_unread_q <= 1'b0;
      a_newer_q  <= 1'b0;
      decim_q    <= 4'h0;
      dma_req    <= 1'b0;
    end else begin
      dma_req <= load_a | load_b;
      if (cap_evt) decim_q <= dec_fire ? 4'h0 : decim_q + 4'h1;
      if (load_a) begin
        cap_a_q   <= count_q;
        a_armed_q <= 1'b1;
        a_newer_q <= 1'b1;
      end else if (load_b) begin
        cap_b_q   <= count_q;
        a_armed_q <= 1'b0;
        a_newer_q <= 1'b0;
      end else if (trig) begin
        a_armed_q <= 1'b0;
      end
      a_unread_q <= load_a | (a_unread_q & ~rd_a);
      b_unread_q <= load_b | (b_unread_q & ~rd_b);
    end
  end

  // Line pins: generator drives line A, and line B unless it is the event input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_a_pin_oe_n <= 1'b1;
      line_b_pin_oe_n <= 1'b1;
      drive_q         <= 1'b0;
    end else begin
      line_a_pin_oe_n <= ~gen_mode;
      line_b_pin_oe_n <= ~(gen_mode & (evt_src != 2'b00));
      drive_q         <= 1'b0;
    end
  end
  assign line_a_pin_o = drive_q;
  assign line_b_pin_o = drive_q;

  // Read mux and APB answer.
  logic [31:0] rdata;
  logic        hit;
  always_comb begin
    rdata = '0;
    hit   = 1'b1;
    unique case (paddr)
      OFS_CMD, OFS_BLK_CMD: rdata = '0;
      OFS_SETUP:   rdata = setup_q;
      OFS_COUNT:   rdata = count_q;
      OFS_CAP_A:   rdata = cap_a_q;
      OFS_CAP_B:   rdata = cap_b_q;
      OFS_CMP_C:   rdata = cmp_c_q;
      OFS_NEXT:    rdata = next_is_a ? cap_a_q : cap_b_q;
      OFS_ROUTING: rdata = {26'h0, routing_q};
      OFS_FLAGS: begin
        rdata[FLG_OVF]    = ovf_q;
        rdata[FLG_OVR]    = ovr_q;
        rdata[FLG_CLK_EN] = en_q;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : '0;
    end
  end

endmodule : tcc_top
`default_nettype wire

// *** test/tcc_pins_model.sv ***
// Partner model: outside clock pins, peer line A levels and the two line pins.
// Assumes pclk from the bench; callers start a pulse train just after a pclk edge.
`timescale 1ns/10ps
`default_nettype none
module tcc_pins_model (
  input  wire logic       pclk,
  input  wire logic       a_o,
  input  wire logic       a_oe_n,
  input  wire logic       b_o,
  input  wire logic       b_oe_n,
  output logic      [2:0] clk_pin,
  output logic      [1:0] peer_a,
  output logic            a_i,
  output logic            b_i
);
  logic [2:0] drv;
  // While the device drives a line it wins; otherwise our level is seen.
  assign a_i = a_oe_n ? drv[1] : a_o;
  assign b_i = b_oe_n ? drv[2] : b_o;
  // Outside clocks stand low between trains, so no stray edge reaches the counter.
  assign clk_pin = {2'b00, drv[0]};
  initial begin
    drv = 3'h0;
    peer_a = 2'h0;
  end
  // Four cycles per level: longer than a pclk and eight times slower than it.
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      drv[p] <= 1'b1;
      repeat (4) @(posedge pclk);
      drv[p] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : pulse
endmodule : tcc_pins_model
`default_nettype wire

// *** test/tcc_assertions.sv ***
// Port-level checker for the timer channel core, bound into tcc_top.
// Assumes the APB master holds each request until pready.
`timescale 1ns/10ps
`default_nettype none
module tcc_assertions
  import tcc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        line_a_pin_oe_n,
  input wire logic        line_b_pin_oe_n,
  input wire logic        dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_decode: assert property (pready |-> pslverr == (paddr > OFS_ROUTING || paddr[1:0] != 2'b00))
    else $error("pslverr does not match address decode");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata nonzero outside read answer");
  chk_capture_inputs: assert property (line_a_pin_oe_n |-> line_b_pin_oe_n)
    else $error("line B driven while line A is an input");
  chk_oe_follows_setup: assert property ($changed(line_a_pin_oe_n) |-> $past(pwrite && paddr == OFS_SETUP, 2))
    else $error("line A direction changed without setup write");
  chk_dma_pulse: assert property (dma_req |=> !dma_req)
    else $error("dma request longer than one cycle");
  cov_unmapped: cover property (pready && pslverr);
  cov_dma: cover property (dma_req);
  cov_generator: cover property (!line_a_pin_oe_n);
endmodule : tcc_assertions
bind tcc_top tcc_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_a_pin_oe_n(line_a_pin_oe_n), .line_b_pin_oe_n(line_b_pin_oe_n), .dma_req(dma_req));
`default_nettype wire

// *** test/timer_channel_capture_core_bench.sv ***
// Self-checking bench for the timer channel core: APB master, pin partner, compares.
// Assumes the partner model and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_capture_core_bench;
  import tcc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat, v, v1;
  logic        pready, pslverr, rerr, a_o, a_oe_n, b_o, b_oe_n, dma_req, a_i, b_i;
  logic [2:0]  clk_pin;
  logic [1:0]  peer_a;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_dma = 0;
  int          seed;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (dma_req === 1'b1) n_dma++;

  tcc_top #(.SLOW_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .outside_clock_pin(clk_pin), .peer_line_a(peer_a), .line_a_pin_i(a_i), .line_a_pin_o(a_o),
    .line_a_pin_oe_n(a_oe_n), .line_b_pin_i(b_i), .line_b_pin_o(b_o), .line_b_pin_oe_n(b_oe_n),
    .dma_req(dma_req));
  tcc_pins_model i_pins (.pclk(pclk), .a_o(a_o), .a_oe_n(a_oe_n), .b_o(b_o), .b_oe_n(b_oe_n),
    .clk_pin(clk_pin), .peer_a(peer_a), .a_i(a_i), .b_i(b_i));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  // Entered just after a rising edge; the request holds until pready is sampled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic count_is(input string nm, input logic [31:0] e);
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk_word(nm, e, rdat);
  endtask : count_is

  initial begin
    seed = 32'h5dbc2985;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("flags_reset", 32'h0, rdat);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      apb(1'b1, OFS_SETUP, v);
      apb(1'b0, OFS_SETUP, 32'h0);
      chk_word("setup_rw", v & SET_MASK, rdat);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk_word("unmapped", 32'h1, {31'h0, rerr});
    // Outside clock 0, trigger on rising line B.
    apb(1'b1, OFS_SETUP, 32'h00000505);
    apb(1'b1, OFS_CMD, 32'h00000001);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("clk_enabled", 32'h1, {31'h0, rdat[FLG_CLK_EN]});
    i_pins.pulse(0, 4);
    count_is("not_started", 32'h0);
    i_pins.pulse(2, 1);
    i_pins.pulse(0, 5);
    count_is("ext_trigger", 32'h4);
    apb(1'b1, OFS_CMD, 32'h00000002);
    apb(1'b1, OFS_CMD, 32'h00000004);
    i_pins.pulse(0, 3);
    count_is("disabled", 32'h0);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("clk_disabled", 32'h0, {31'h0, rdat[FLG_CLK_EN]});
    apb(1'b1, OFS_CMD, 32'h00000001);
    apb(1'b1, OFS_BLK_CMD, 32'h00000001);
    i_pins.pulse(0, 6);
    count_is("sync", 32'h5);
    apb(1'b1, OFS_SETUP, 32'h0000050d);
    apb(1'b1, OFS_CMD, 32'h00000004);
    i_pins.pulse(0, 6);
    count_is("inverted", 32'h5);
    apb(1'b1, OFS_ROUTING, 32'h00000024);
    apb(1'b1, OFS_SETUP, 32'h00000525);
    apb(1'b1, OFS_CMD, 32'h00000004);
    i_pins.pulse(0, 6);
    count_is("burst_low", 32'h5);
    i_pins.peer_a <= 2'h1;
    apb(1'b1, OFS_SETUP, 32'h00000535);
    apb(1'b1, OFS_CMD, 32'h00000004);
    i_pins.pulse(0, 7);
    count_is("burst_chain", 32'h6);
    i_pins.peer_a <= 2'h0;
    apb(1'b1, OFS_CMP_C, 32'h0000000a);
    apb(1'b1, OFS_SETUP, 32'h00004000);
    apb(1'b1, OFS_CMD, 32'h00000004);
    for (int i = 0; i < 6; i++) begin
      repeat (($random(seed) & 32'h1f) + 5) @(posedge pclk);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk_word("c_restart", 32'h1, {31'h0, rdat <= 32'ha});
    end
    apb(1'b1, OFS_SETUP, 32'h00008000);
    repeat (4) @(posedge pclk);
    chk_word("gen_oe", 32'h1, {28'h0, a_o, b_o, a_oe_n, b_oe_n});
    apb(1'b1, OFS_SETUP, 32'h00008800);
    repeat (4) @(posedge pclk);
    chk_word("gen_oe_b", 32'h0, {28'h0, a_o, b_o, a_oe_n, b_oe_n});
    // Capture: A on rising, B on falling line A.
    apb(1'b1, OFS_SETUP, 32'h00090000);
    apb(1'b1, OFS_CMD, 32'h00000004);
    n_dma = 0;
    i_pins.pulse(1, 1);
    repeat (8) @(posedge pclk);
    chk_word("dma_pair", 32'h2, n_dma);
    apb(1'b0, OFS_NEXT, 32'h0);
    v1 = rdat;
    apb(1'b0, OFS_NEXT, 32'h0);
    chk_word("a_before_b", 32'h1, {31'h0, rdat > v1});
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("no_overrun", 32'h0, {31'h0, rdat[FLG_OVR]});
    i_pins.pulse(1, 2);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("overrun", 32'h1, {31'h0, rdat[FLG_OVR]});
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk_word("overrun_clear", 32'h0, {31'h0, rdat[FLG_OVR]});
    for (int d = 0; d < 5; d++) begin
      apb(1'b1, OFS_SETUP, 32'h000f0000 | (d << SET_DECIM));
      apb(1'b1, OFS_CMD, 32'h00000004);
      n_dma = 0;
      i_pins.pulse(1, 16);
      repeat (8) @(posedge pclk);
      chk_word("decimation", 32'd32 >> d, n_dma);
    end
    complete_run();
  end
endmodule : timer_channel_capture_core_bench
`default_nettype wire
